// File: logic/sram_port_pkg.sv
// Purpose: shared constants and types for the burst sram port
// Assumes: one ref_clk cycle per input clock edge (k or k-bar)
// Notes: edge counts are in half cycles of the input clock
`default_nettype none
package sram_port_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 36;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int BEATS = 4;
    localparam int BURST_W = BEATS * DATA_W;
    localparam int BLANE_W = BEATS * LANES;
    // depth of the modelled array, word address bits kept
    localparam int DEPTH_W = 10;
    // edges from the start edge to first write and read beat
    localparam int WR_FIRST = 2;
    localparam int RD_FIRST = 5;
    localparam int WR_SPAN = WR_FIRST + BEATS - 1;
    localparam int PIPE_LEN = RD_FIRST + BEATS - 1;
    localparam logic [LANES-1:0] WIDE_MASK = 4'hf;
    localparam logic [LANES-1:0] NARROW_MASK = 4'h3;
    localparam logic [LANES-1:0] NO_LANES_N = 4'hf;

    typedef logic [ADDR_W-1:0] addr_t;
    typedef logic [DATA_W-1:0] data_t;
    typedef logic [LANES-1:0] lane_t;
    typedef logic [BURST_W-1:0] burst_t;
    typedef logic [BLANE_W-1:0] burst_lane_t;
    typedef logic [DEPTH_W-1:0] mem_idx_t;

    // one started access, as held in the edge history
    typedef struct packed {
        logic valid;
        logic is_rd;
        addr_t addr;
    } start_t;

    // address of a given beat within a burst
    function automatic addr_t beat_addr(input addr_t a, input int b);
        return a + addr_t'(b);
    endfunction

    // spread a lane mask over the data bits it guards
    function automatic data_t lane_bits(input lane_t m);
        data_t r;
        r = '0;
        for (int l = 0; l < LANES; l++) begin
            r[l*LANE_W +: LANE_W] = {LANE_W{m[l]}};
        end
        return r;
    endfunction
endpackage
`default_nettype wire

// File: logic/sram_port_if.sv
// Purpose: pins between the memory controller and the burst sram
// Assumes: k_edge marks a ref_clk cycle holding an input clock edge
// Notes: q_oe low stands for high impedance on the read data pins
`timescale 1ns/10ps
`default_nettype none
interface sram_port_if;
    import sram_port_pkg::*;
    logic k_edge;
    logic k_true;
    logic read_port_select_n;
    logic write_port_select_n;
    addr_t addr;
    data_t d;
    lane_t lane_write_select_n;
    data_t q;
    logic q_oe;

    modport device (
        input k_edge,
        input k_true,
        input read_port_select_n,
        input write_port_select_n,
        input addr,
        input d,
        input lane_write_select_n,
        output q,
        output q_oe
    );

    modport controller (
        output k_edge,
        output k_true,
        output read_port_select_n,
        output write_port_select_n,
        output addr,
        output d,
        output lane_write_select_n,
        input q,
        input q_oe
    );
endinterface
`default_nettype wire

// File: logic/burst_sram_device.sv
// Purpose: cycle model of the burst sram, four-beat read and write bursts
// Assumes: the controller keeps the select spacing and clock parking
// Notes: only the low DEPTH_W address bits reach the array
//
// Summary of operation
// [R1] write: select low at k, four beats follow
// [R2] read: select low at k, data 2.5 cycles on
// [R3] read beats on successive edges, last at k+4
// [R4] write beats three and four at k+2 and k-bar
// [R5] beats use address then next three locations
// [R6] data taken and launched on both clock edges
// [R7] both selects high: no operation, outputs off
// [R8] after reset deselected, outputs high impedance
// [R9] same access type on consecutive k: second dropped
// [R10] select low at last start is don't care
// [R11] narrow organisation: two lanes of nine bits
// [R12] wide organisation: four lanes of nine bits
// [R13] lane selects sampled anew with every beat
// [R14] controller parks clocks high when stopping
// [R15] stopped clocks freeze all state and outputs
// [R16] both selected from idle: alternate, read first
// [R17] read after write returns the newest data
`timescale 1ns/10ps
`default_nettype none
module burst_sram_device #(
    parameter bit WIDE_ORG = 1'b1
) (
    input wire logic ref_clk,
    input wire logic reset,
    sram_port_if.device port
);
    import sram_port_pkg::*;

    // whole registered state of the port
    typedef struct packed {
        start_t [PIPE_LEN-1:0] pipe;
        data_t q;
        logic q_oe;
    } dev_state_t;

    dev_state_t st_reg;
    dev_state_t st_next;

    // array write port, driven from the combinational step
    logic wr_en;
    mem_idx_t wr_idx;
    lane_t wr_mask;
    mem_idx_t rd_idx;
    start_t start;
    lane_t org_mask;
    logic prev_rd;
    logic prev_wr;

    data_t mem [2**DEPTH_W];

    // lanes that exist in the chosen organisation
    assign org_mask = WIDE_ORG ? WIDE_MASK : NARROW_MASK; // R11 R12

    // history slot 1 is the access started at the previous k rise
    assign prev_rd = st_reg.pipe[1].valid && st_reg.pipe[1].is_rd;
    assign prev_wr = st_reg.pipe[1].valid && !st_reg.pipe[1].is_rd;

    // one step per input clock edge; no edge means standby
    always_comb begin
        st_next = st_reg;
        wr_en = 1'b0;
        wr_idx = '0;
        wr_mask = '0;
        rd_idx = '0;
        start = '0;
        if (port.k_edge) begin // R15
            // selects are looked at on the true clock only
            if (port.k_true) begin
                if (!port.read_port_select_n && !prev_rd) begin // R2 R9 R10 R16
                    start.valid = 1'b1;
                    start.is_rd = 1'b1;
                    start.addr = port.addr;
                end else if (!port.write_port_select_n && !prev_wr) begin // R1 R9 R10
                    start.valid = 1'b1;
                    start.is_rd = 1'b0;
                    start.addr = port.addr;
                end
            end
            // write beats: slot j started j+1 edges ago
            for (int j = WR_FIRST - 1; j < WR_SPAN; j++) begin
                if (st_reg.pipe[j].valid && !st_reg.pipe[j].is_rd) begin // R1 R4 R6
                    wr_en = 1'b1;
                    wr_idx = mem_idx_t'(beat_addr(st_reg.pipe[j].addr,
                        j - (WR_FIRST - 1))); // R5
                    wr_mask = ~port.lane_write_select_n & org_mask; // R11 R12 R13
                end
            end
            // read beats launch on every edge; off when none due
            st_next.q_oe = 1'b0; // R7
            for (int j = RD_FIRST - 1; j < PIPE_LEN; j++) begin
                if (st_reg.pipe[j].valid && st_reg.pipe[j].is_rd) begin // R2 R3 R6
                    rd_idx = mem_idx_t'(beat_addr(st_reg.pipe[j].addr,
                        j - (RD_FIRST - 1))); // R5
                    st_next.q_oe = 1'b1;
                end
            end
            // array read; sees the word as stored before any write landing on this edge
            st_next.q = st_next.q_oe ? (mem[rd_idx] & lane_bits(org_mask)) : '0; // R17
            // age the edge history by one edge
            st_next.pipe[0] = start;
            for (int j = 1; j < PIPE_LEN; j++) begin
                st_next.pipe[j] = st_reg.pipe[j-1];
            end
        end
    end

    // state register; reset leaves both ports deselected
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_reg <= '0; // R8
        end else begin
            st_reg <= st_next;
        end
    end

    // byte lanes merge into the stored word as each beat lands
    always_ff @(posedge ref_clk) begin
        if (!reset && wr_en) begin
            for (int l = 0; l < LANES; l++) begin
                if (wr_mask[l]) begin // R11 R12
                    mem[wr_idx][l*LANE_W +: LANE_W] <= port.d[l*LANE_W +: LANE_W];
                end
            end
        end
    end

    // read data pins straight from the launch register
    assign port.q = st_reg.q;
    assign port.q_oe = st_reg.q_oe;
endmodule
`default_nettype wire

// File: logic/burst_sram_controller.sv
// Purpose: memory controller end, issues bursts and collects reads
// Assumes: requests arrive already split into four-beat bursts
// Notes: two write buffers cover back-to-back write bursts
`timescale 1ns/10ps
`default_nettype none
module burst_sram_controller (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clock_run,
    input wire logic req_valid,
    input wire logic req_write,
    input wire sram_port_pkg::addr_t req_addr,
    input wire sram_port_pkg::burst_t req_wdata,
    input wire sram_port_pkg::burst_lane_t req_lanes_n,
    output logic req_ready,
    output logic rsp_valid,
    output sram_port_pkg::burst_t rsp_data,
    sram_port_if.controller port
);
    import sram_port_pkg::*;

    typedef struct packed {
        logic phase;
        logic last_rd;
        logic last_wr;
        logic rsel_n;
        logic wsel_n;
        addr_t addr;
        data_t d;
        lane_t lanes_n;
        logic [1:0][BURST_W-1:0] wbuf;
        logic [1:0][BLANE_W-1:0] wlane;
        logic wslot;
        logic [WR_SPAN-1:0] hist_v;
        logic [WR_SPAN-1:0] hist_s;
        logic [1:0] rbeat;
        burst_t rdata;
        logic rsp_valid;
    } ctl_state_t;

    ctl_state_t st_reg;
    ctl_state_t st_next;
    logic run;
    logic legal;
    logic slot;
    int beat;

    // stop only before a k rise, so both clocks rest high
    assign run = st_reg.phase ? clock_run : 1'b1; // R14
    // no same-type start on consecutive k rises
    assign legal = req_write ? !st_reg.last_wr : !st_reg.last_rd; // R9
    assign req_ready = !st_reg.phase && legal;

    // prepare pins for the coming edge while this one runs
    always_comb begin
        st_next = st_reg;
        st_next.rsp_valid = 1'b0;
        slot = 1'b0;
        beat = 0;
        if (run) begin
            st_next.phase = !st_reg.phase;
            st_next.hist_v = {st_reg.hist_v[WR_SPAN-2:0], st_reg.phase && !st_reg.wsel_n};
            st_next.hist_s = {st_reg.hist_s[WR_SPAN-2:0], !st_reg.wslot};
            if (st_reg.phase) begin
                st_next.last_rd = !st_reg.rsel_n;
                st_next.last_wr = !st_reg.wsel_n;
                st_next.rsel_n = 1'b1; // R7
                st_next.wsel_n = 1'b1;
            end
            // write beat for the next edge, per-beat lanes
            st_next.lanes_n = NO_LANES_N;
            for (int j = WR_FIRST - 1; j < WR_SPAN; j++) begin
                if (st_next.hist_v[j]) begin // R1 R13
                    slot = st_next.hist_s[j];
                    beat = j - (WR_FIRST - 1);
                    st_next.d = st_reg.wbuf[slot][beat*DATA_W +: DATA_W];
                    st_next.lanes_n = st_reg.wlane[slot][beat*LANES +: LANES];
                end
            end
            // q on the pins was launched by the previous edge
            if (port.q_oe) begin // R2
                st_next.rdata[st_reg.rbeat*DATA_W +: DATA_W] = port.q;
                st_next.rbeat = st_reg.rbeat + 2'h1;
                st_next.rsp_valid = (st_reg.rbeat == 2'(BEATS - 1));
            end
            // accept a request for the coming k rise
            if (!st_reg.phase && req_valid && legal) begin // R1 R2
                st_next.rsel_n = req_write;
                st_next.wsel_n = !req_write;
                st_next.addr = req_addr;
                if (req_write) begin
                    st_next.wbuf[st_reg.wslot] = req_wdata;
                    st_next.wlane[st_reg.wslot] = req_lanes_n;
                    st_next.wslot = !st_reg.wslot;
                end
            end
        end
    end

    // state register; next edge after reset is a k rise
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_reg <= '0;
            st_reg.phase <= 1'b1;
            st_reg.rsel_n <= 1'b1;
            st_reg.wsel_n <= 1'b1;
            st_reg.lanes_n <= NO_LANES_N;
        end else begin
            st_reg <= st_next;
        end
    end

    assign port.k_edge = run;
    assign port.k_true = st_reg.phase;
    assign port.read_port_select_n = st_reg.rsel_n;
    assign port.write_port_select_n = st_reg.wsel_n;
    assign port.addr = st_reg.addr;
    assign port.d = st_reg.d;
    assign port.lane_write_select_n = st_reg.lanes_n;
    assign rsp_valid = st_reg.rsp_valid;
    assign rsp_data = st_reg.rdata;
endmodule
`default_nettype wire

// File: dv/sram_port_checker.sv
// Purpose: protocol checks on the wires between controller and device
// Assumes: each k_edge cycle is one input clock edge
// Notes: history counts edges, so stopped clocks do not skew it
`timescale 1ns/10ps
`default_nettype none
module sram_port_checker (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic k_edge,
    input wire logic k_true,
    input wire logic read_port_select_n,
    input wire logic write_port_select_n,
    input wire sram_port_pkg::addr_t addr,
    input wire sram_port_pkg::data_t d,
    input wire sram_port_pkg::lane_t lane_write_select_n,
    input wire sram_port_pkg::data_t q,
    input wire logic q_oe
);
    import sram_port_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic rd_prev_reg;
    logic wr_prev_reg;
    logic [7:0] rd_hist_reg;
    logic [7:0] wr_hist_reg;
    wire logic k_rise = k_edge && k_true;
    // read wins a k rise unless it started at the previous one
    wire logic rd_go = k_rise && !read_port_select_n && !rd_prev_reg;
    wire logic wr_go = k_rise && !write_port_select_n && !wr_prev_reg && !rd_go;
    // write beats are due at edges 2 to 5 after a write start
    wire logic wr_due = wr_hist_reg[4:1] != 4'h0;
    // starts shifted per edge; beats due at edges 5 to 8
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rd_prev_reg <= 1'b0;
            wr_prev_reg <= 1'b0;
            rd_hist_reg <= 8'h00;
            wr_hist_reg <= 8'h00;
        end else if (k_edge) begin
            rd_hist_reg <= {rd_hist_reg[6:0], rd_go};
            wr_hist_reg <= {wr_hist_reg[6:0], wr_go};
            if (k_true) begin
                rd_prev_reg <= rd_go;
                wr_prev_reg <= wr_go;
            end
        end
    end
    a_reset_q_off: assert property (disable iff (1'b0) reset |=> !q_oe)
        else $error("read port driven after reset");
    a_off_q_zero: assert property (!q_oe |-> q == '0)
        else $error("read data not quiet while off");
    a_beat_drives_q: assert property (k_edge && rd_hist_reg[7:4] != 4'h0 |=> q_oe)
        else $error("read beat missing");
    a_idle_q_off: assert property (k_edge && rd_hist_reg[7:4] == 4'h0 |=> !q_oe)
        else $error("read port driven with no beat due");
    a_stall_holds: assert property (!k_edge |=> $stable(q) && $stable(q_oe))
        else $error("read port moved while clock stopped");
    a_k_alternates: assert property (k_edge |=> k_true != $past(k_true))
        else $error("clock edges do not alternate");
    a_read_spacing: assert property (k_rise && rd_prev_reg |-> read_port_select_n)
        else $error("reads on consecutive k rises");
    a_write_spacing: assert property (k_rise && wr_prev_reg |-> write_port_select_n)
        else $error("writes on consecutive k rises");
    a_parked_high: assert property (!k_edge |-> k_true)
        else $error("clock stopped away from k rise");
    a_lanes_idle: assert property (k_edge && !wr_due |-> lane_write_select_n == '1)
        else $error("lane selects low with no write beat due");
    cover property (rd_go);
    cover property (wr_go);
    cover property (!k_edge && q_oe);
endmodule
`default_nettype wire

// File: dv/testbench.sv
// Purpose: drives the controller user side against the device
// Assumes: both ends joined by one sram_port_if
// Notes: expected bursts are built here from written data
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import sram_port_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic clock_run = 1'b1;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    addr_t req_addr = '0;
    burst_t req_wdata = '0;
    burst_lane_t req_lanes_n = '1;
    logic req_ready;
    logic rsp_valid;
    burst_t rsp_data;
    int mismatches = 0;
    int num_checks = 0;
    burst_t got, w1, w2;
    burst_t narrow_data;
    burst_t got_narrow;
    sram_port_if port_if ();
    sram_port_if narrow_if ();
    always #2.5 ref_clk = ~ref_clk;
    burst_sram_controller burst_sram_controller_inst (.ref_clk(ref_clk), .reset(reset),
        .clock_run(clock_run), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_lanes_n(req_lanes_n),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .port(port_if.controller));
    burst_sram_device #(.WIDE_ORG(1'b1)) burst_sram_device_inst (.ref_clk(ref_clk),
        .reset(reset), .port(port_if.device));
    sram_port_checker sram_port_checker_inst (.ref_clk(ref_clk), .reset(reset),
        .k_edge(port_if.k_edge), .k_true(port_if.k_true),
        .read_port_select_n(port_if.read_port_select_n),
        .write_port_select_n(port_if.write_port_select_n), .addr(port_if.addr),
        .d(port_if.d), .lane_write_select_n(port_if.lane_write_select_n),
        .q(port_if.q), .q_oe(port_if.q_oe));
    // narrow pair fed the same requests, so both organisations share one stimulus
    burst_sram_controller burst_sram_controller_narrow_inst (.ref_clk(ref_clk),
        .reset(reset), .clock_run(clock_run), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_lanes_n(req_lanes_n), .req_ready(), .rsp_valid(), .rsp_data(narrow_data),
        .port(narrow_if.controller));
    burst_sram_device #(.WIDE_ORG(1'b0)) burst_sram_device_narrow_inst (.ref_clk(ref_clk),
        .reset(reset), .port(narrow_if.device));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic give_up();
        mismatches++;
        complete_run();
    endtask
    task automatic check(input burst_t seen, input burst_t exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // four beats counting up from s
    function automatic burst_t pat(input logic [31:0] s);
        burst_t r;
        for (int b = 0; b < 4; b++) r[b*36 +: 36] = {4'ha, s + b};
        return r;
    endfunction
    // a high lane select keeps the old bits of that lane
    function automatic burst_t merge(input burst_t o, input burst_t n, input burst_lane_t ln);
        burst_t r;
        for (int i = 0; i < 144; i++) r[i] = ln[(i / 36) * 4 + (i % 36) / 9] ? o[i] : n[i];
        return r;
    endfunction
    // narrow organisation keeps lanes 0 and 1 of each beat, upper bits read 0
    function automatic burst_t narrow(input burst_t b);
        burst_t r;
        for (int i = 0; i < 144; i++) r[i] = ((i % 36) < 18) ? b[i] : 1'b0;
        return r;
    endfunction
    // held until taken; the extra edge keeps req_valid single-driven per step
    task automatic issue(input logic wr, input addr_t a, input burst_t w, input burst_lane_t ln);
        int n;
        req_write <= wr;
        req_addr <= a;
        req_wdata <= w;
        req_lanes_n <= ln;
        req_valid <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(negedge ref_clk);
            if (req_ready === 1'b1) break;
        end
        if (n == 20) give_up();
        @(posedge ref_clk);
        req_valid <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd_burst(input addr_t a, input int stall, output burst_t r);
        int n;
        issue(1'b0, a, '0, '1);
        // stop after the first beat so the pins must hold it through the stall
        if (stall > 0) begin
            repeat (5) @(posedge ref_clk);
            clock_run <= 1'b0;
            repeat (stall) @(posedge ref_clk);
            clock_run <= 1'b1;
        end
        for (n = 0; n < 60; n++) begin
            @(negedge ref_clk);
            if (rsp_valid === 1'b1) break;
        end
        if (n == 60) give_up();
        r = rsp_data;
        got_narrow = narrow_data;
        @(posedge ref_clk);
    endtask
    task automatic sc_reset();
        check(burst_t'(port_if.q_oe), '0);
    endtask
    // two bursts, read back aligned and one word on
    task automatic sc_burst();
        w1 = pat(32'h100);
        w2 = pat(32'h200);
        issue(1'b1, 19'h00040, w1, '0);
        issue(1'b1, 19'h00044, w2, '0);
        rd_burst(19'h00040, 0, got);
        check(got, w1);
        check(got_narrow, narrow(w1));
        rd_burst(19'h00041, 0, got);
        check(got, {w2[35:0], w1[143:36]});
    endtask
    // lanes differ per beat, one beat writes nothing
    task automatic sc_lanes();
        issue(1'b1, 19'h00040, pat(32'h300), 16'h70fe);
        rd_burst(19'h00040, 0, got);
        check(got, merge(w1, pat(32'h300), 16'h70fe));
        check(got_narrow, narrow(merge(w1, pat(32'h300), 16'h70fe)));
    endtask
    // read on the k rise right after the write start
    task automatic sc_forward();
        issue(1'b1, 19'h00048, w2, '0);
        rd_burst(19'h00048, 0, got);
        check(got, w2);
    endtask
    task automatic sc_stall();
        rd_burst(19'h00048, 12, got);
        check(got, w2);
    endtask
    initial begin
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        sc_reset();
        sc_burst();
        sc_lanes();
        sc_forward();
        sc_stall();
        complete_run();
    end
endmodule
`default_nettype wire
